// ---- pbr_pkg.sv ----
// Purpose: Shared constants for the push-button, reset and status output block
// Assumes: 100 MHz core clock
// Notes: Times are in their own unit, pulse and release cycle counts derived here
package pbr_pkg;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned FAULT_PULSE_US = 128;
  localparam int unsigned FAULT_PULSE_CYC = FAULT_PULSE_US * CLK_MHZ;
  localparam int unsigned RESET_RELEASE_MS = 400;
  localparam longint unsigned RESET_RELEASE_CYC = 64'(RESET_RELEASE_MS) * 1000 * CLK_MHZ;
  localparam int unsigned CNT_W = 32;
  localparam logic [1:0] HOLD_FIELD_RST = 2'h0;
  // Hold time choices, milliseconds, indexed by the hold-time field
  localparam int unsigned HOLD_MS_0 = 5000;
  localparam int unsigned HOLD_MS_1 = 9000;
  localparam int unsigned HOLD_MS_2 = 11000;
  localparam int unsigned HOLD_MS_3 = 15000;
  localparam int unsigned SYNC_STAGES = 3;
  // Thermistor zone codes
  typedef enum logic [2:0] {
    PBR_TS_NORMAL,
    PBR_TS_COLD,
    PBR_TS_COOL,
    PBR_TS_WARM,
    PBR_TS_HOT
  } pbr_ts_zone_t;
endpackage : pbr_pkg

// ---- pbr_sync_if.sv ----
// Purpose: Carrier between the top and the button synchroniser
// Assumes: Single clock domain
// Notes: Level plus one-cycle edge flags
`timescale 1ns/1ps
interface pbr_sync_if;
  logic level;
  logic fell;
  logic rose;
  modport src (output level, output fell, output rose);
  modport dst (input level, input fell, input rose);
endinterface : pbr_sync_if

// ---- pbr_button_sync.sv ----
// Purpose: Three-stage synchroniser for the push-button pin
// Assumes: Pin is asynchronous to clk_i, idles high
// Notes: Change counts once stages two and three agree
`timescale 1ns/1ps
module pbr_button_sync
  import pbr_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic pin_i,
  pbr_sync_if.src sync
);
  logic [2:0] stage_r;
  logic [2:0] stage_nxt;
  logic level_r;
  logic level_nxt;
  logic fell_r;
  logic fell_nxt;
  logic rose_r;
  logic rose_nxt;

  always_comb begin
    stage_nxt = {stage_r[1:0], pin_i};
    level_nxt = level_r;
    if (stage_r[1] == stage_r[2]) begin
      level_nxt = stage_r[2];
    end
    fell_nxt = level_r & ~level_nxt;
    rose_nxt = ~level_r & level_nxt;
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stage_r <= 3'h7;
      level_r <= 1'h1;
      fell_r <= 1'h0;
      rose_r <= 1'h0;
    end else begin
      stage_r <= stage_nxt;
      level_r <= level_nxt;
      fell_r <= fell_nxt;
      rose_r <= rose_nxt;
    end
  end

  assign sync.level = level_r;
  assign sync.fell = fell_r;
  assign sync.rose = rose_r;
endmodule : pbr_button_sync

// ---- pbr_status_top.sv ----
// Purpose: Status, power-good, push-button reset and wake logic
// Assumes: Analog comparators deliver clean levels on clk_i
// Notes: Open-drain pins are enable-only, pin low while enable high
// How it works
// - Status pin held low for the whole time charging runs.
// - Status pin released when done, disabled, or charger in high-impedance mode.
// - Each fault starts or restarts a 128 us low pulse on the status pin.
// - Indicator enable bit gates the charging-low indication.
// - Power-good low when input above battery plus margin and below overvoltage.
// - Button-shifted mode makes power-good follow the button level.
// - Reset output low once button held longer than programmed hold time.
// - Reset output released after fixed 400 ms delay.
// - Two programmable wake timers raise host interrupts for shorter presses.
// - Button activity brings the device out of ship mode.
// - Thermistor level classed against four thresholds; faults reported in charge mode.
`timescale 1ns/1ps
module pbr_status_top
  import pbr_pkg::*;
#(
  parameter longint unsigned RELEASE_CYC = RESET_RELEASE_CYC,
  parameter longint unsigned HOLD_UNIT_CYC = 64'(CLK_MHZ) * 1000
)
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic charging_i,
  input wire logic charge_done_i,
  input wire logic charge_disabled_i,
  input wire logic charger_hiz_i,
  input wire logic fault_event_i,
  input wire logic indicator_enable_i,
  input wire logic in_above_bat_margin_i,
  input wire logic in_below_overvoltage_i,
  input wire logic button_shifted_output_mode_i,
  input wire logic manual_button_n_i,
  input wire logic [1:0] button_hold_time_field_i,
  input wire logic [CNT_W-1:0] first_wake_time_i,
  input wire logic [CNT_W-1:0] second_wake_time_i,
  input wire logic ship_mode_i,
  input wire logic [3:0] thermistor_sense_in_i,
  output logic status_int_oe_o,
  output logic input_power_good_out_oe_o,
  output logic reset_out_oe_o,
  output logic wake1_irq_o,
  output logic wake2_irq_o,
  output logic ship_exit_o,
  output logic [2:0] thermistor_zone_o,
  output logic thermistor_fault_o
);
  pbr_sync_if btn ();

  pbr_button_sync u_sync (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .pin_i(manual_button_n_i),
    .sync(btn.src)
  );

  typedef enum logic [1:0] {
    PBR_IDLE,
    PBR_PRESSED,
    PBR_RESET_HELD,
    PBR_WAIT_RELEASE
  } pbr_state_t;

  // ======================================================================
  // Status pin
  // ======================================================================
  logic [CNT_W-1:0] pulse_cnt_r;
  logic [CNT_W-1:0] pulse_cnt_nxt;
  logic status_oe_r;
  logic status_oe_nxt;

  always_comb begin
    pulse_cnt_nxt = pulse_cnt_r;
    if (fault_event_i) begin
      pulse_cnt_nxt = CNT_W'(FAULT_PULSE_CYC);
    end else if (pulse_cnt_r != '0) begin
      pulse_cnt_nxt = pulse_cnt_r - 1'b1;
    end
    status_oe_nxt = 1'b0;
    if (charging_i && indicator_enable_i && !charge_done_i && !charge_disabled_i && !charger_hiz_i) begin
      status_oe_nxt = 1'b1;
    end
    if (pulse_cnt_nxt != '0) begin
      status_oe_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pulse_cnt_r <= '0;
      status_oe_r <= 1'b0;
    end else begin
      pulse_cnt_r <= pulse_cnt_nxt;
      status_oe_r <= status_oe_nxt;
    end
  end

  assign status_int_oe_o = status_oe_r;

  // ======================================================================
  // Power-good pin
  // ======================================================================
  logic pg_oe_r;
  logic pg_oe_nxt;

  always_comb begin
    if (button_shifted_output_mode_i) begin
      pg_oe_nxt = ~btn.level;
    end else begin
      pg_oe_nxt = in_above_bat_margin_i & in_below_overvoltage_i;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pg_oe_r <= 1'b0;
    end else begin
      pg_oe_r <= pg_oe_nxt;
    end
  end

  assign input_power_good_out_oe_o = pg_oe_r;

  // ======================================================================
  // Button timing, wake events and reset output
  // ======================================================================
  pbr_state_t state_r;
  pbr_state_t state_nxt;
  logic [CNT_W-1:0] press_cnt_r;
  logic [CNT_W-1:0] press_cnt_nxt;
  logic [CNT_W-1:0] rel_cnt_r;
  logic [CNT_W-1:0] rel_cnt_nxt;
  logic wake1_r;
  logic wake1_nxt;
  logic wake2_r;
  logic wake2_nxt;
  logic ship_exit_r;
  logic ship_exit_nxt;
  logic [CNT_W-1:0] hold_cyc;
  longint unsigned hold_ms;

  always_comb begin
    case (button_hold_time_field_i)
      2'h0: hold_ms = 64'(HOLD_MS_0);
      2'h1: hold_ms = 64'(HOLD_MS_1);
      2'h2: hold_ms = 64'(HOLD_MS_2);
      default: hold_ms = 64'(HOLD_MS_3);
    endcase
    hold_cyc = CNT_W'(hold_ms * HOLD_UNIT_CYC);
  end

  always_comb begin
    state_nxt = state_r;
    press_cnt_nxt = press_cnt_r;
    rel_cnt_nxt = rel_cnt_r;
    wake1_nxt = 1'b0;
    wake2_nxt = 1'b0;
    ship_exit_nxt = 1'b0;
    if (btn.fell && ship_mode_i) begin
      ship_exit_nxt = 1'b1;
    end
    case (state_r)
      PBR_IDLE: begin
        press_cnt_nxt = '0;
        if (btn.fell) begin
          state_nxt = PBR_PRESSED;
        end
      end
      PBR_PRESSED: begin
        if (btn.level) begin
          state_nxt = PBR_IDLE;
          press_cnt_nxt = '0;
        end else begin
          press_cnt_nxt = press_cnt_r + 1'b1;
          if (press_cnt_nxt == first_wake_time_i) begin
            wake1_nxt = 1'b1;
          end
          if (press_cnt_nxt == second_wake_time_i) begin
            wake2_nxt = 1'b1;
          end
          if (press_cnt_r > hold_cyc) begin
            state_nxt = PBR_RESET_HELD;
            rel_cnt_nxt = CNT_W'(RELEASE_CYC);
          end
        end
      end
      PBR_RESET_HELD: begin
        rel_cnt_nxt = rel_cnt_r - 1'b1;
        if (rel_cnt_r <= 1) begin
          state_nxt = PBR_WAIT_RELEASE;
        end
      end
      default: begin
        press_cnt_nxt = '0;
        if (btn.level) begin
          state_nxt = PBR_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r <= PBR_IDLE;
      press_cnt_r <= '0;
      rel_cnt_r <= '0;
      wake1_r <= 1'b0;
      wake2_r <= 1'b0;
      ship_exit_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      press_cnt_r <= press_cnt_nxt;
      rel_cnt_r <= rel_cnt_nxt;
      wake1_r <= wake1_nxt;
      wake2_r <= wake2_nxt;
      ship_exit_r <= ship_exit_nxt;
    end
  end

  assign reset_out_oe_o = (state_r == PBR_RESET_HELD);
  assign wake1_irq_o = wake1_r;
  assign wake2_irq_o = wake2_r;
  assign ship_exit_o = ship_exit_r;

  // ======================================================================
  // Thermistor classification
  // ======================================================================
  logic [2:0] zone_r;
  logic [2:0] zone_nxt;
  logic ts_fault_r;
  logic ts_fault_nxt;

  // Input bits are comparator trips: [0] cold, [1] cool, [2] warm, [3] hot
  always_comb begin
    if (thermistor_sense_in_i[0]) begin
      zone_nxt = PBR_TS_COLD;
    end else if (thermistor_sense_in_i[3]) begin
      zone_nxt = PBR_TS_HOT;
    end else if (thermistor_sense_in_i[1]) begin
      zone_nxt = PBR_TS_COOL;
    end else if (thermistor_sense_in_i[2]) begin
      zone_nxt = PBR_TS_WARM;
    end else begin
      zone_nxt = PBR_TS_NORMAL;
    end
    ts_fault_nxt = charging_i && (zone_nxt != PBR_TS_NORMAL);
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      zone_r <= PBR_TS_NORMAL;
      ts_fault_r <= 1'b0;
    end else begin
      zone_r <= zone_nxt;
      ts_fault_r <= ts_fault_nxt;
    end
  end

  assign thermistor_zone_o = zone_r;
  assign thermistor_fault_o = ts_fault_r;
endmodule : pbr_status_top

// ---- pbr_status_monitor.sv ----
// Purpose: Port-level checks on the status, power-good and button reset block
// Assumes: Single clock, asynchronous active-low reset
// Notes: Hold counter measures how long the reset pin stays pulled low
`timescale 1ns/1ps
module pbr_status_monitor
  import pbr_pkg::*;
#(
  parameter longint unsigned RELEASE_CYC = RESET_RELEASE_CYC
)
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic charging_i,
  input wire logic charge_done_i,
  input wire logic charge_disabled_i,
  input wire logic charger_hiz_i,
  input wire logic fault_event_i,
  input wire logic indicator_enable_i,
  input wire logic in_above_bat_margin_i,
  input wire logic in_below_overvoltage_i,
  input wire logic button_shifted_output_mode_i,
  input wire logic manual_button_n_i,
  input wire logic ship_mode_i,
  input wire logic [3:0] thermistor_sense_in_i,
  input wire logic status_int_oe_o,
  input wire logic input_power_good_out_oe_o,
  input wire logic reset_out_oe_o,
  input wire logic wake1_irq_o,
  input wire logic ship_exit_o,
  input wire logic [2:0] thermistor_zone_o,
  input wire logic thermistor_fault_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  logic [CNT_W-1:0] hold_r;
  logic [CNT_W-1:0] hold_nxt;
  always_comb hold_nxt = reset_out_oe_o ? hold_r + 1'b1 : '0;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) hold_r <= '0;
    else hold_r <= hold_nxt;
  end
  a_charge_low: assert property ((charging_i && indicator_enable_i && !charge_done_i && !charge_disabled_i
    && !charger_hiz_i) |=> status_int_oe_o) else $error("status not low while charging");
  a_fault_pulse: assert property (fault_event_i |=> status_int_oe_o [*8]) else $error("fault pulse missing");
  a_pg_good: assert property ((!button_shifted_output_mode_i && in_above_bat_margin_i && in_below_overvoltage_i)
    |=> input_power_good_out_oe_o) else $error("power good not low");
  a_pg_bad: assert property ((!button_shifted_output_mode_i && !(in_above_bat_margin_i && in_below_overvoltage_i))
    |=> !input_power_good_out_oe_o) else $error("power good not released");
  a_reset_press: assert property ($rose(reset_out_oe_o) |-> !$past(manual_button_n_i, 4))
    else $error("reset without press");
  a_reset_length: assert property ($fell(reset_out_oe_o) |-> hold_r == CNT_W'(RELEASE_CYC))
    else $error("reset length wrong");
  a_wake_press: assert property (wake1_irq_o |-> !$past(manual_button_n_i, 6)) else $error("wake without press");
  a_ship_exit: assert property (ship_exit_o |-> $past(ship_mode_i)) else $error("ship exit outside ship mode");
  a_therm_fault: assert property (thermistor_fault_o |-> $past(charging_i)) else $error("fault outside charge");
  a_therm_hot: assert property (thermistor_sense_in_i == 4'h8 |=> thermistor_zone_o == 3'h4)
    else $error("hot zone wrong");
endmodule : pbr_status_monitor
bind pbr_status_top pbr_status_monitor #(.RELEASE_CYC(RELEASE_CYC)) i_mon (.clk_i(clk_i), .reset_n_i(reset_n_i),
  .charging_i(charging_i), .charge_done_i(charge_done_i), .charge_disabled_i(charge_disabled_i),
  .charger_hiz_i(charger_hiz_i), .fault_event_i(fault_event_i), .indicator_enable_i(indicator_enable_i),
  .in_above_bat_margin_i(in_above_bat_margin_i), .in_below_overvoltage_i(in_below_overvoltage_i),
  .button_shifted_output_mode_i(button_shifted_output_mode_i), .manual_button_n_i(manual_button_n_i),
  .ship_mode_i(ship_mode_i), .thermistor_sense_in_i(thermistor_sense_in_i), .status_int_oe_o(status_int_oe_o),
  .input_power_good_out_oe_o(input_power_good_out_oe_o), .reset_out_oe_o(reset_out_oe_o),
  .wake1_irq_o(wake1_irq_o), .ship_exit_o(ship_exit_o), .thermistor_zone_o(thermistor_zone_o),
  .thermistor_fault_o(thermistor_fault_o));

// ---- pbr_button_model.sv ----
// Purpose: User push-button on the pulled-up button pin
// Assumes: Presses start and end on rising clock edges
// Notes: Pin idles high, each press is followed by a settle gap
`timescale 1ns/1ps
module pbr_button_model (
  input wire logic clk_i,
  output logic pin_n_o
);
  initial pin_n_o = 1'b1;
  task automatic press(input int n);
    @(posedge clk_i) pin_n_o <= 1'b0;
    repeat (n) @(posedge clk_i);
    pin_n_o <= 1'b1;
    repeat (10) @(posedge clk_i);
    #1;
  endtask : press
endmodule : pbr_button_model

// ---- tb.sv ----
// Purpose: Directed bench for the status and push-button block
// Assumes: Shortened hold unit and release count
// Notes: Pulse outputs are counted every cycle
`timescale 1ns/1ps
module tb;
  import pbr_pkg::*;
  localparam longint unsigned REL = 20;
  logic clk = 0, rst_n = 0, chg = 0, flt = 0, ind = 1, abv = 0, blw = 0, shf = 0, shp = 0, btn_n;
  logic st, pg, rs, k1, k2, se, tf;
  logic [2:0] rel = 3'h0, zn;
  logic [3:0] ts = 4'h0;
  logic [1:0] hold = 2'h0;
  logic [31:0] w1 = 32'h0A, w2 = 32'h14;
  int mismatches = 0, checks_done = 0, n1 = 0, n2 = 0, ns = 0, nr = 0;
  always #5 clk = ~clk;
  pbr_button_model i_btn (.clk_i(clk), .pin_n_o(btn_n));
  pbr_status_top #(.RELEASE_CYC(REL), .HOLD_UNIT_CYC(64'h2)) i_dut (.clk_i(clk), .reset_n_i(rst_n),
    .charging_i(chg), .charge_done_i(rel[0]), .charge_disabled_i(rel[1]), .charger_hiz_i(rel[2]),
    .fault_event_i(flt), .indicator_enable_i(ind), .in_above_bat_margin_i(abv), .in_below_overvoltage_i(blw),
    .button_shifted_output_mode_i(shf), .manual_button_n_i(btn_n), .button_hold_time_field_i(hold),
    .first_wake_time_i(w1), .second_wake_time_i(w2), .ship_mode_i(shp), .thermistor_sense_in_i(ts),
    .status_int_oe_o(st), .input_power_good_out_oe_o(pg), .reset_out_oe_o(rs), .wake1_irq_o(k1),
    .wake2_irq_o(k2), .ship_exit_o(se), .thermistor_zone_o(zn), .thermistor_fault_o(tf));
  always @(posedge clk) begin
    if (k1 === 1'b1) n1++;
    if (k2 === 1'b1) n2++;
    if (se === 1'b1) ns++;
    if (rs === 1'b1) nr++;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic end_of_test();
    if (mismatches == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test
  // ==========
  // Sequence
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk) chg <= 1'b1;
    cyc(2); chk(st, 1);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk) rel <= 3'h1 << i;
      cyc(2); chk(st, 0);
    end
    @(posedge clk) begin rel <= 3'h0; ind <= 1'b0; end
    cyc(2); chk(st, 0);
    @(posedge clk) begin chg <= 1'b0; flt <= 1'b1; end
    @(posedge clk) flt <= 1'b0;
    cyc(FAULT_PULSE_CYC - 1); chk(st, 1);
    cyc(2); chk(st, 0);
    @(posedge clk) begin abv <= 1'b1; blw <= 1'b1; end
    cyc(2); chk(pg, 1);
    @(posedge clk) blw <= 1'b0;
    cyc(2); chk(pg, 0);
    @(posedge clk) shf <= 1'b1;
    fork
      i_btn.press(15);
      begin cyc(10); chk(pg, 1); end
    join
    chk(pg, 0);
    chk(n1, 1); chk(n2, 0);
    i_btn.press(30);
    chk(n1, 2); chk(n2, 1);
    i_btn.press(15);
    i_btn.press(15);
    chk(n1, 4); chk(n2, 1);
    @(posedge clk) w2 <= 32'h05;
    i_btn.press(15);
    chk(n1, 5); chk(n2, 2);
    i_btn.press(9990);
    chk(nr, 0);
    i_btn.press(10050);
    chk(nr, 32'(REL));
    // Longer hold selection: same press no longer resets
    @(posedge clk) hold <= 2'h1;
    i_btn.press(10050);
    chk(nr, 32'(REL));
    chk(ns, 0);
    @(posedge clk) shp <= 1'b1;
    i_btn.press(15);
    chk(ns, 1);
    @(posedge clk) begin chg <= 1'b1; ts <= 4'h8; end
    cyc(2); chk(zn, 4); chk(tf, 1);
    @(posedge clk) ts <= 4'h9;
    cyc(2); chk(zn, 1);
    end_of_test();
  end
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    end_of_test();
  end
endmodule : tb
